// >>> hw/kbi_detect.sv
`timescale 1ns/1ps
module kbi_detect (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] pins_i,
  input wire logic [7:0] pin_en_i,
  input wire logic [3:0] pol_i,
  input wire logic mode_i,
  input wire logic stop_i,
  kbi_evt_if.det evt
);
  // ****************************************
  // synchroniser and sample history
  // ****************************************
  logic [7:0] sync1_reg, sync1_next;
  logic [7:0] sync2_reg, sync2_next;
  logic [7:0] prev_reg, prev_next;
  logic [7:0] pol_full;
  logic [7:0] act_now;
  logic [7:0] act_prev;

  always_comb
  begin
    sync1_next = pins_i;
    sync2_next = sync1_reg;
    prev_next = sync2_reg;
  end

  // history reset to high (deasserted for low-active pins)
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync1_reg <= kbi_pkg::RST_SYNC;
      sync2_reg <= kbi_pkg::RST_SYNC;
      prev_reg <= kbi_pkg::RST_SYNC;
    end
    else
    begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      prev_reg <= prev_next;
    end
  end

  // pins 3..0 fixed falling/low, 7..4 selectable
  assign pol_full = {pol_i, 4'h0};
  // asserted level per pin, gated by enable
  assign act_now = (sync2_reg ^ ~pol_full) & pin_en_i;
  assign act_prev = (prev_reg ^ ~pol_full) & pin_en_i;

  // one sample per cycle: deasserted then asserted
  // new assertions while the other pins stayed deasserted
  assign evt.edge_hit = ~stop_i && ((act_now & ~act_prev) != 8'h00)
    && ((act_prev & act_now) == 8'h00);
  assign evt.level_hold = mode_i && (act_now != 8'h00);
  assign evt.asserted = act_now;
  // stop mode: raw level wake, no clock needed
  assign evt.wake = stop_i && (((pins_i ^ ~pol_full) & pin_en_i) != 8'h00);
endmodule : kbi_detect

// >>> hw/kbi_top.sv
`timescale 1ns/1ps
// Operation
// - inputs sampled once per clock; deasserted level must precede an edge
// - falling edge: high in one cycle, low the next
// - rising edge: low in one cycle, high the next
// - mode 0 sets flag when pins newly assert while others stay deasserted
// - mode 1 holds flag set while any enabled pin stays asserted
// - stop mode: enabled pins act as asynchronous level wake sources
// - any detected edge on an enabled pin sets the event flag
// - irq enable 1 requests interrupt while event flag is 1
// - writing 1 to acknowledge clears the event flag
// - mode 0: acknowledge write clears the flag unless an edge is detected in the same cycle
// - pins 3..0 falling/low; pins 7..4 follow their polarity bit
// - only pins with enable bit 1 take part in detection
// - acknowledge bit is write-only, reads as 0
// - irq enable 0: no interrupt, flag still set and readable
module kbi_top (
  input wire logic SYS_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HSEL_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  input wire logic [7:0] KEY_PINS_I,
  output logic KEY_IRQ_O,
  output logic KEY_WAKE_O,
  output logic KEY_INT_O
);
  // ****************************************
  // bus address phase capture
  // ****************************************
  logic wr_pend_reg, wr_pend_next;
  logic rd_pend_reg, rd_pend_next;
  logic [7:0] addr_reg, addr_next;
  logic phase_ok;

  // hsize ignored: only whole-word singles are used on this bus
  assign phase_ok = HSEL_I && HREADY_I && HTRANS_I[1];

  always_comb
  begin
    wr_pend_next = phase_ok && HWRITE_I;
    rd_pend_next = phase_ok && !HWRITE_I;
    addr_next = phase_ok ? HADDR_I[7:0] : addr_reg;
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
    end
    else
    begin
      wr_pend_reg <= wr_pend_next;
      rd_pend_reg <= rd_pend_next;
      addr_reg <= addr_next;
    end
  end

  assign HREADYOUT_O = 1'b1;
  assign HRESP_O = 1'b0;

  // ****************************************
  // control registers
  // ****************************************
  logic mode_reg, mode_next;
  logic irq_en_reg, irq_en_next;
  logic [3:0] pol_reg, pol_next;
  logic [7:0] pin_en_reg, pin_en_next;
  logic stop_reg, stop_next;
  logic flag_reg, flag_next;
  logic [1:0] ist_reg, ist_next;
  logic [1:0] imask_reg, imask_next;
  logic [31:0] rdata_reg, rdata_next;
  logic wr_sc, wr_pe, wr_im, wr_md, rd_is;
  logic ack;
  logic wake_q_reg, wake_q_next;
  logic wake_sync;
  kbi_evt_if evt ();

  assign wr_sc = wr_pend_reg && (addr_reg == kbi_pkg::ADDR_STATUS_CONTROL);
  assign wr_pe = wr_pend_reg && (addr_reg == kbi_pkg::ADDR_PIN_ENABLE);
  assign wr_im = wr_pend_reg && (addr_reg == kbi_pkg::ADDR_IRQ_MASK);
  assign wr_md = wr_pend_reg && (addr_reg == kbi_pkg::ADDR_MODE_CONTROL);
  assign rd_is = rd_pend_reg && (addr_reg == kbi_pkg::ADDR_IRQ_STATUS);
  assign ack = wr_sc && HWDATA_I[kbi_pkg::POS_ACK];
  // status sees the synchronised level; the raw wake path is not clocked logic
  assign wake_sync = stop_reg && (evt.asserted != 8'h00);

  kbi_detect u_detect (
    .clk_i(SYS_CLK_I),
    .rst_i(SYS_RST_I),
    .pins_i(KEY_PINS_I),
    .pin_en_i(pin_en_reg),
    .pol_i(pol_reg),
    .mode_i(mode_reg),
    .stop_i(stop_reg),
    .evt(evt.det)
  );

  always_comb
  begin
    mode_next = wr_sc ? HWDATA_I[kbi_pkg::POS_MODE] : mode_reg;
    irq_en_next = wr_sc ? HWDATA_I[kbi_pkg::POS_IRQ_EN] : irq_en_reg;
    pol_next = wr_sc ? HWDATA_I[kbi_pkg::POS_POL_LO +: 4] : pol_reg;
    pin_en_next = wr_pe ? HWDATA_I[7:0] : pin_en_reg;
    imask_next = wr_im ? HWDATA_I[1:0] : imask_reg;
    stop_next = wr_md ? HWDATA_I[kbi_pkg::POS_STOP] : stop_reg;
    // ack clears in either mode, but setting wins
    flag_next = flag_reg && !ack;
    // edge sets flag; level hold overrides ack
    if (evt.edge_hit || evt.level_hold)
      flag_next = 1'b1;
    // sticky event status, cleared by its read; new events win
    ist_next = rd_is ? 2'h0 : ist_reg;
    if (evt.edge_hit)
      ist_next[kbi_pkg::POS_EVT_SET] = 1'b1;
    if (wake_sync && !wake_q_reg)
      ist_next[kbi_pkg::POS_EVT_WAKE] = 1'b1;
    wake_q_next = wake_sync;
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      mode_reg <= 1'b0;
      irq_en_reg <= 1'b0;
      pol_reg <= kbi_pkg::RST_POLARITY;
      pin_en_reg <= kbi_pkg::RST_PIN_ENABLE;
      imask_reg <= kbi_pkg::RST_IRQ_MASK;
      stop_reg <= 1'b0;
      flag_reg <= 1'b0;
      ist_reg <= 2'h0;
      wake_q_reg <= 1'b0;
    end
    else
    begin
      mode_reg <= mode_next;
      irq_en_reg <= irq_en_next;
      pol_reg <= pol_next;
      pin_en_reg <= pin_en_next;
      imask_reg <= imask_next;
      stop_reg <= stop_next;
      flag_reg <= flag_next;
      ist_reg <= ist_next;
      wake_q_reg <= wake_q_next;
    end
  end

  // ****************************************
  // read data, registered in the address phase's next cycle
  // ****************************************
  always_comb
  begin
    rdata_next = 32'h0000_0000;
    if (phase_ok && !HWRITE_I)
    begin
      case (HADDR_I[7:0])
        kbi_pkg::ADDR_STATUS_CONTROL:
          // ack position always reads 0
          rdata_next = {24'h000000, pol_reg, flag_reg, 1'b0, irq_en_reg, mode_reg};
        kbi_pkg::ADDR_PIN_ENABLE:
          rdata_next = {24'h000000, pin_en_reg};
        kbi_pkg::ADDR_IRQ_STATUS:
          rdata_next = {30'h00000000, ist_reg};
        kbi_pkg::ADDR_IRQ_MASK:
          rdata_next = {30'h00000000, imask_reg};
        kbi_pkg::ADDR_MODE_CONTROL:
          rdata_next = {31'h00000000, stop_reg};
        default:
          rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
      rdata_reg <= 32'h0000_0000;
    else
      rdata_reg <= rdata_next;
  end

  assign HRDATA_O = rdata_reg;

  // ****************************************
  // outputs
  // ****************************************
  // flag polls with irq enable 0, requests with 1
  assign KEY_IRQ_O = flag_reg && irq_en_reg;
  // asynchronous path so a halted clock still wakes
  assign KEY_WAKE_O = evt.wake;
  assign KEY_INT_O = (ist_reg & imask_reg) != 2'h0;
endmodule : kbi_top

// >>> inc/kbi_evt_if.sv
`timescale 1ns/1ps
// detector results passed to the register block
interface kbi_evt_if;
  logic [7:0] asserted;
  logic edge_hit;
  logic level_hold;
  logic wake;
  modport det (output asserted, output edge_hit, output level_hold, output wake);
  modport ctl (input asserted, input edge_hit, input level_hold, input wake);
endinterface : kbi_evt_if

// >>> inc/kbi_pkg.sv
package kbi_pkg;
  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [7:0] ADDR_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_PIN_ENABLE = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
  localparam logic [7:0] ADDR_MODE_CONTROL = 8'h10;
  // ****************************************
  // register field positions and pin counts
  // ****************************************
  localparam int POS_MODE = 0;
  localparam int POS_IRQ_EN = 1;
  localparam int POS_ACK = 2;
  localparam int POS_FLAG = 3;
  localparam int POS_POL_LO = 4;
  localparam int POS_STOP = 0;
  localparam int POS_EVT_SET = 0;
  localparam int POS_EVT_WAKE = 1;
  localparam int NUM_PINS = 8;
  localparam int NUM_FIXED_PINS = 4;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic [3:0] RST_POLARITY = 4'h0;
  localparam logic [7:0] RST_PIN_ENABLE = 8'h00;
  localparam logic [1:0] RST_IRQ_MASK = 2'h0;
  localparam logic [7:0] RST_SYNC = 8'hff;
endpackage : kbi_pkg

// >>> verification/kbi_keypad.sv
`timescale 1ns/1ps
module kbi_keypad (
  input wire logic [7:0] press_i,
  input wire logic [7:0] high_act_i,
  output logic [7:0] pins_o
);
  // a released key rests on its pull, the inverse of the active level
  assign pins_o = press_i ~^ high_act_i;
endmodule : kbi_keypad

// >>> verification/kbi_top_bench.sv
`timescale 1ns/1ps
module kbi_top_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [7:0] haddr = 8'h00;
  logic [7:0] press = 8'h00;
  logic [7:0] hact = 8'h00;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [7:0] pins;
  logic hready, hresp, irq, wake, kint;
  int fails = 0;
  int total_checks = 0;
  always #20 clk = ~clk;
  kbi_keypad PAD (.press_i(press), .high_act_i(hact), .pins_o(pins));
  kbi_top DUT (.SYS_CLK_I(clk), .SYS_RST_I(rst), .HADDR_I({24'h0, haddr}),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
    .HSEL_I(1'b1), .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready),
    .HRESP_O(hresp), .KEY_PINS_I(pins), .KEY_IRQ_O(irq), .KEY_WAKE_O(wake), .KEY_INT_O(kint));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    q = hrdata;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    chk(n, q, e);
  endtask : rd
  task automatic key(input logic [7:0] p);
    press <= p;
    tick(6);
  endtask : key
  task automatic t_fall;
    for (int i = 0; i < 6; i++) rd("reset", 8'(4 * i), 32'h0);
    wr(8'h04, 32'h01);
    wr(8'h00, 32'h02);
    chk("hresp", 32'(hresp), 32'h0);
    key(8'h02);
    chk("irq off pin", 32'(irq), 32'h0);
    key(8'h03);
    chk("irq fall", 32'(irq), 32'h1);
    rd("flag", 8'h00, 32'h0a);
    key(8'h00);
    wr(8'h00, 32'h06);
    tick(1);
    chk("irq ack", 32'(irq), 32'h0);
    wr(8'h04, 32'h03);
    wr(8'h00, 32'h00);
    key(8'h02);
    chk("irq poll", 32'(irq), 32'h0);
    rd("poll", 8'h00, 32'h08);
    wr(8'h00, 32'h04);
    rd("ack", 8'h00, 32'h0);
    key(8'h03);
    rd("others held", 8'h00, 32'h0);
    key(8'h00);
  endtask : t_fall
  task automatic t_rise;
    hact <= 8'h10;
    wr(8'h00, 32'h10);
    wr(8'h04, 32'h10);
    key(8'h10);
    rd("rise", 8'h00, 32'h18);
    wr(8'h00, 32'h14);
    key(8'h00);
    rd("rise only", 8'h00, 32'h10);
    wr(8'h04, 32'h01);
    hact <= 8'h00;
    wr(8'h00, 32'h03);
    key(8'h01);
    wr(8'h00, 32'h07);
    rd("hold", 8'h00, 32'h0b);
    key(8'h00);
    wr(8'h00, 32'h07);
    rd("freed", 8'h00, 32'h03);
  endtask : t_rise
  task automatic t_evt;
    wr(8'h00, 32'h00);
    wr(8'h0c, 32'h01);
    key(8'h01);
    chk("int", 32'(kint), 32'h1);
    rd("status", 8'h08, 32'h01);
    tick(1);
    chk("int read", 32'(kint), 32'h0);
    key(8'h00);
    wr(8'h0c, 32'h00);
    wr(8'h00, 32'h04);
    wr(8'h10, 32'h01);
    press <= 8'h01;
    tick(1);
    chk("wake", 32'(wake), 32'h1);
    key(8'h00);
    chk("wake off", 32'(wake), 32'h0);
    rd("wake st", 8'h08, 32'h02);
    rd("no edge", 8'h00, 32'h0);
  endtask : t_evt
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  initial
  begin
    tick(2);
    rst <= 1'b0;
    t_fall();
    t_rise();
    t_evt();
    wrap_up();
  end
  initial
  begin
    #100000;
    fails++;
    wrap_up();
  end
endmodule : kbi_top_bench
bind kbi_top kbi_chk CHK (.SYS_CLK_I(SYS_CLK_I), .SYS_RST_I(SYS_RST_I), .HADDR_I(HADDR_I),
  .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HWDATA_I(HWDATA_I), .HSEL_I(HSEL_I),
  .HRDATA_O(HRDATA_O), .KEY_PINS_I(KEY_PINS_I), .KEY_IRQ_O(KEY_IRQ_O), .KEY_WAKE_O(KEY_WAKE_O));

// >>> verification/kbi_top_properties.sv
`timescale 1ns/1ps
module kbi_chk (
  input wire logic SYS_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HRDATA_O,
  input wire logic [7:0] KEY_PINS_I,
  input wire logic KEY_IRQ_O,
  input wire logic KEY_WAKE_O
);
  logic v_reg, w_reg, rd0, wc, f1, f0, lv;
  logic [7:0] a_reg, ctl_reg, pe_reg;
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (SYS_RST_I);
  // shadow of control writes, landing with the data phase like the real one
  always_ff @(posedge SYS_CLK_I)
  begin
    v_reg <= HSEL_I && HTRANS_I[1];
    w_reg <= HWRITE_I;
    a_reg <= HADDR_I[7:0];
    if (SYS_RST_I)
      ctl_reg <= 8'h00;
    else if (wc)
      ctl_reg <= HWDATA_I[7:0];
    if (SYS_RST_I)
      pe_reg <= 8'h00;
    else if (v_reg && w_reg && a_reg == 8'h04)
      pe_reg <= HWDATA_I[7:0];
  end
  assign rd0 = v_reg && !w_reg && a_reg == 8'h00;
  assign wc = v_reg && w_reg && a_reg == 8'h00;
  assign f1 = ctl_reg[1] && pe_reg == 8'h01 && KEY_PINS_I[0];
  assign f0 = ctl_reg[1] && pe_reg == 8'h01 && !KEY_PINS_I[0];
  assign lv = ctl_reg[1:0] == 2'h3 && pe_reg[0] && !KEY_PINS_I[0];
  chk_ack_zero: assert property (rd0 |-> !HRDATA_O[2])
    else $error("ack bit read back as one");
  chk_irq_gated: assert property (!ctl_reg[1] |-> !KEY_IRQ_O)
    else $error("interrupt while disabled");
  chk_irq_flag: assert property (rd0 && HRDATA_O[3] && ctl_reg[1] |-> KEY_IRQ_O)
    else $error("flag set without interrupt");
  chk_ack_clear: assert property (wc && HWDATA_I[2] && !HWDATA_I[0] |=> !KEY_IRQ_O)
    else $error("ack did not clear flag");
  chk_reset_idle: assert property ($fell(SYS_RST_I) |-> !KEY_IRQ_O && !KEY_WAKE_O)
    else $error("outputs busy after reset");
  chk_fall_edge: assert property (f1[*3] ##1 f0[*5] |-> KEY_IRQ_O)
    else $error("falling edge missed");
  chk_level_hold: assert property (lv[*6] |-> KEY_IRQ_O)
    else $error("level hold lost");
  chk_wake_off: assert property (pe_reg == 8'h00 |-> !KEY_WAKE_O)
    else $error("wake without enabled pin");
endmodule : kbi_chk
